// ---- src/status_mux_pkg.sv ----
// constants, row codes and carrier structs of the status output multiplexer
package status_mux_pkg;
	// register addresses
	localparam logic [9:0] ADDR_POINTER  = 10'h035;
	localparam logic [9:0] ADDR_ENABLE   = 10'h036;
	localparam logic [9:0] ADDR_LOCKMODE = 10'h037;
	localparam logic [9:0] ADDR_STATUS   = 10'h038;
	// reset values
	localparam logic [7:0] POINTER_RST  = 8'h00;
	localparam logic [7:0] ENABLE_RST   = 8'hff;
	localparam logic [1:0] LOCKMODE_RST = 2'h0;
	// status register field positions
	localparam int ST_CAL_DONE = 0;
	localparam int ST_TX_PUMP  = 1;
	localparam int ST_RX_PUMP  = 2;
	localparam int ST_TX_LOCK  = 3;
	localparam int ST_RX_LOCK  = 4;
	localparam int ST_BB_LOCK  = 5;
	// synthesizer index in lock arrays
	localparam int SYN_TX = 0;
	localparam int SYN_RX = 1;
	localparam int SYN_BB = 2;
	// row codes of the pointer register
	localparam logic [7:0] ROW_CAL_DONE  = 8'h00;
	localparam logic [7:0] ROW_PLL_LOCK  = 8'h01;
	localparam logic [7:0] ROW_CAL_BUSY  = 8'h02;
	localparam logic [7:0] ROW_OVERLOAD  = 8'h03;
	localparam logic [7:0] ROW_GAIN2     = 8'h04;
	localparam logic [7:0] ROW_AGC2      = 8'h05;
	localparam logic [7:0] ROW_GAIN1     = 8'h06;
	localparam logic [7:0] ROW_AGC1      = 8'h07;
	localparam logic [7:0] ROW_FAST_AGC  = 8'h08;
	localparam logic [7:0] ROW_RXTX_ON   = 8'h09;
	localparam logic [7:0] ROW_OVF1      = 8'h0a;
	localparam logic [7:0] ROW_SEQ_STATE = 8'h0b;
	localparam logic [7:0] ROW_PEAK      = 8'h0c;
	localparam logic [7:0] ROW_TX_QUAD   = 8'h0d;
	localparam logic [7:0] ROW_BB_DC     = 8'h0e;
	localparam logic [7:0] ROW_STATE1    = 8'h0f;
	localparam logic [7:0] ROW_STATE2    = 8'h10;
	localparam logic [7:0] ROW_AUX_WORD  = 8'h11;
	localparam logic [7:0] ROW_POWER1    = 8'h12;
	localparam logic [7:0] ROW_POWER2    = 8'h13;
	localparam logic [7:0] ROW_OVF2      = 8'h14;
	localparam logic [7:0] ROW_TRACK1    = 8'h15;
	localparam logic [7:0] ROW_INDEX1    = 8'h16;
	localparam logic [7:0] ROW_INDEX2    = 8'h17;
	localparam logic [7:0] ROW_TRACK2    = 8'h18;
	localparam logic [7:0] ROW_PUMP_CODE = 8'h19;
	localparam logic [7:0] ROW_RX_LEVEL  = 8'h1a;
	localparam logic [7:0] ROW_TX_LEVEL  = 8'h1b;
	localparam logic [7:0] ROW_RX_TUNE   = 8'h1c;
	localparam logic [7:0] ROW_TX_TUNE   = 8'h1d;
	localparam logic [7:0] ROW_THRESH1   = 8'h1e;
	localparam logic [7:0] ROW_THRESH2   = 8'h1f;

	// calibration running levels from the sequencer
	typedef struct packed {
		logic rfOffset, bbOffset, rx1Quad, tx1Quad, rx2Quad, tx2Quad;
		logic gainStep, txMon, rxFilter, txFilter, rxVco, txVco;
		logic txPump, rxPump, seqPending;
	} cal_busy_s;

	// per-channel receive and transmit status
	typedef struct packed {
		logic       lowPower, lgMix, lgConv, smConv, gainLock;
		logic       energyLost, stronger, gainChange, filtPwrRdy, convPwrRdy;
		logic [2:0] agcState;
		logic [6:0] gain;
		logic       signalPresent, dcUpdate, dcMeasure, dcTrackCnt;
		logic       rssiEn, decPwrEn, convPwrEn, lowThresh, highThresh;
		logic       gainUpdExp, resetPeak, digSat;
		logic [1:0] rfOffsetState, txQuadStatus;
		logic       txQuadDone, rssiPreRdy, rssiSymRdy;
		logic [6:0] overflow;
	} chan_stat_s;

	// synthesizer calibration results
	typedef struct packed {
		logic [8:0] tune;
		logic [6:0] levelCode;
		logic [3:0] pumpCode;
	} synth_cal_s;

	// device wide status
	typedef struct packed {
		logic        rxOn, txOn, gainFreeze, tempValid, auxValid;
		logic [11:0] auxWord;
		logic [3:0]  seqState, radioState;
	} misc_stat_s;

	// register port request
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic       wr, rd;
	} reg_req_s;
endpackage

// ---- src/sync_three.sv ----
// three-stage input synchroniser with agreement filter
module sync_three #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             cen,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_r; // metastable stage, read only by s2
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// shift chain
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end
		else if (cen)
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end

	// a bit moves only once stages two and three agree
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			dout <= '0;
		else if (cen)
			dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
endmodule // sync_three

// ---- src/status_output_mux.sv ----
// status output multiplexer: row pointer, pin enable, calibration flags
// Operation
// R01: pins show pointer row, disabled pins low
// R02: cal done low at reset, tracks listed cals
// R03: sequenced cals: done rises after all finish
// R04: tx pump done low, low during runs
// R05: rx pump done follows rx pump cal
// R06: filter tuning done high, low while tuning
// R07: gain step and rx vco busy flags
// R08: row two shows per-cal busy flags
// R09: row one locks, pins four-zero low
// R10: continuous lock: locked and no cal
// R11: single shot lock sampled after vco cal
// R12: baseband lock pin follows baseband lock
// R13: row three pin seven channel one low power
// R14: undefined row bits carry no meaning
// R15: host waits for calibration end
// R16: row 0x15 channel one tracking, low nibble zero
// R17: row 0x18 channel two tracking and enables
// R18: row 0x1e thresholds, gain state, valids
// R19: rows 0x12/0x13 power and gain state
// R20: rows 0x1a-0x1d vco calibration results
// R21: row 0x0d tx quadrature status fields
// R22: row 0x14 channel two overflow flags
// R23: row 0x10 channel two state fields
// R24: row zero pin zero is tx vco busy
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
module status_output_mux (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       cen,
	input  wire status_mux_pkg::reg_req_s   regReq,
	output logic [7:0]                      rdData,
	input  wire status_mux_pkg::cal_busy_s  calBusy,
	input  wire status_mux_pkg::chan_stat_s chan1,
	input  wire status_mux_pkg::chan_stat_s chan2,
	input  wire status_mux_pkg::synth_cal_s txSynth,
	input  wire status_mux_pkg::synth_cal_s rxSynth,
	input  wire status_mux_pkg::misc_stat_s misc,
	input  wire logic [2:0]                 pllLockRaw,
	input  wire logic [1:0]                 intWordWrite,
	output logic [7:0]                      statusPins
);
	logic [7:0] pointer_r;   // selected row
	logic [7:0] enable_r;    // per-pin enable
	logic [1:0] lockMode_r;  // 1 = single shot detector
	logic [2:0] lockSync;    // filtered lock levels
	logic       calDone_r;   // all listed cals finished
	logic       runPrev_r;   // listed run active last cycle
	logic [1:0] pumpDone_r;  // charge pump cal done flags
	logic [1:0] pumpPrev_r;  // pump busy last cycle
	logic [1:0] armed_r;     // integer word written, awaiting vco cal
	logic [1:0] shot_r;      // single shot lock result
	logic [1:0] vcoPrev_r;   // vco busy last cycle
	logic [1:0] lockPin;     // rf lock pin values
	logic [1:0] pumpBusy;    // pump busy per synth
	logic [1:0] vcoBusy;     // vco busy per synth
	logic       listedBusy;  // a cal that moves cal done runs
	logic       runActive;   // listed cal running or pending
	logic       anyCalBusy;  // any calibration at all
	logic [7:0] rowBits;     // selected row before masking
	logic [7:0] statusWord;  // status register view

	// lock levels arrive from the analog side, so filter them
	sync_three #(
		.WIDTH (3)
	) u_lock_sync (
		.clk    (clk),
		.resetn (resetn),
		.cen    (cen),
		.din    (pllLockRaw),
		.dout   (lockSync)
	);

	// calibration groupings
	assign listedBusy = calBusy.rfOffset | calBusy.bbOffset | calBusy.rx1Quad
		| calBusy.tx1Quad | calBusy.rx2Quad | calBusy.tx2Quad
		| calBusy.gainStep;
	// pending keeps cal done low between sequenced steps
	assign runActive  = listedBusy | calBusy.seqPending; // R03
	assign anyCalBusy = listedBusy | calBusy.txMon | calBusy.rxFilter
		| calBusy.txFilter | calBusy.rxVco | calBusy.txVco
		| calBusy.txPump | calBusy.rxPump;
	assign pumpBusy = {calBusy.rxPump, calBusy.txPump};
	assign vcoBusy  = {calBusy.rxVco, calBusy.txVco};

	// register writes
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			pointer_r  <= status_mux_pkg::POINTER_RST;
			enable_r   <= status_mux_pkg::ENABLE_RST;
			lockMode_r <= status_mux_pkg::LOCKMODE_RST;
		end
		else if (cen && regReq.wr)
		begin
			if (regReq.addr == status_mux_pkg::ADDR_POINTER)
				pointer_r <= regReq.wdata;
			else if (regReq.addr == status_mux_pkg::ADDR_ENABLE)
				enable_r <= regReq.wdata;
			else if (regReq.addr == status_mux_pkg::ADDR_LOCKMODE)
				lockMode_r <= regReq.wdata[1:0];
			// other addresses: write ignored
		end

	// status register view of block state
	always_comb
	begin
		statusWord = 8'h00;
		statusWord[status_mux_pkg::ST_CAL_DONE] = calDone_r;
		statusWord[status_mux_pkg::ST_TX_PUMP]  = pumpDone_r[status_mux_pkg::SYN_TX];
		statusWord[status_mux_pkg::ST_RX_PUMP]  = pumpDone_r[status_mux_pkg::SYN_RX];
		statusWord[status_mux_pkg::ST_TX_LOCK]  = lockPin[status_mux_pkg::SYN_TX];
		statusWord[status_mux_pkg::ST_RX_LOCK]  = lockPin[status_mux_pkg::SYN_RX];
		statusWord[status_mux_pkg::ST_BB_LOCK]  = lockSync[status_mux_pkg::SYN_BB];
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			rdData <= 8'h00;
		else if (cen)
		begin
			if (!regReq.rd)
				rdData <= 8'h00;
			else if (regReq.addr == status_mux_pkg::ADDR_POINTER)
				rdData <= pointer_r;
			else if (regReq.addr == status_mux_pkg::ADDR_ENABLE)
				rdData <= enable_r;
			else if (regReq.addr == status_mux_pkg::ADDR_LOCKMODE)
				rdData <= {6'h00, lockMode_r};
			else if (regReq.addr == status_mux_pkg::ADDR_STATUS)
				rdData <= statusWord;
			else
				rdData <= 8'h00; // unmapped reads zero
		end

	// cal done: low from reset, cleared by any listed run or pending step, set when runs end
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			calDone_r <= 1'b0; // R02
			runPrev_r <= 1'b0;
		end
		else if (cen)
		begin
			runPrev_r <= runActive;
			if (runActive)
				calDone_r <= 1'b0; // R02
			else if (runPrev_r)
				calDone_r <= 1'b1; // R03
		end

	// charge pump and single shot lock, one copy per rf synth
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_synth
			// pump done: low during a run, high once it ends
			always_ff @(posedge clk or negedge resetn)
				if (!resetn)
				begin
					pumpDone_r[g] <= 1'b0; // R04 R05
					pumpPrev_r[g] <= 1'b0;
				end
				else if (cen)
				begin
					pumpPrev_r[g] <= pumpBusy[g];
					if (pumpBusy[g])
						pumpDone_r[g] <= 1'b0; // R04 R05
					else if (pumpPrev_r[g])
						pumpDone_r[g] <= 1'b1; // R04 R05
				end

			// single shot: sample lock when the vco cal after a word write ends;
			// a fresh write in the same cycle rearms and wins
			always_ff @(posedge clk or negedge resetn)
				if (!resetn)
				begin
					armed_r[g]   <= 1'b0;
					shot_r[g]    <= 1'b0;
					vcoPrev_r[g] <= 1'b0;
				end
				else if (cen)
				begin
					vcoPrev_r[g] <= vcoBusy[g];
					if (armed_r[g] && vcoPrev_r[g] && !vcoBusy[g])
						shot_r[g] <= lockSync[g]; // R11
					if (intWordWrite[g])
						armed_r[g] <= 1'b1;
					else if (vcoPrev_r[g] && !vcoBusy[g])
						armed_r[g] <= 1'b0; // R11
				end

			// continuous mode never reports lock while a cal runs
			assign lockPin[g] = lockMode_r[g] ? shot_r[g]
				: (lockSync[g] & ~anyCalBusy); // R10 R11
		end
	endgenerate

	// row selection; rows and pins with no signal drive low
	always_comb
	begin
		rowBits = 8'h00; // R14
		case (pointer_r)
			status_mux_pkg::ROW_CAL_DONE:
				rowBits = {calDone_r, pumpDone_r[status_mux_pkg::SYN_TX], // R02
					pumpDone_r[status_mux_pkg::SYN_RX], // R05
					~calBusy.rxFilter, ~calBusy.txFilter, // R06
					calBusy.gainStep, calBusy.rxVco, // R07
					calBusy.txVco}; // R24
			status_mux_pkg::ROW_PLL_LOCK:
				rowBits = {lockPin[status_mux_pkg::SYN_TX], lockPin[status_mux_pkg::SYN_RX],
					lockSync[status_mux_pkg::SYN_BB], 5'h00}; // R09 R12
			status_mux_pkg::ROW_CAL_BUSY:
				rowBits = {calBusy.bbOffset, calBusy.rfOffset, calBusy.rx1Quad,
					calBusy.tx1Quad, calBusy.rx2Quad, calBusy.tx2Quad,
					calBusy.gainStep, calBusy.txMon}; // R08
			status_mux_pkg::ROW_OVERLOAD:
				rowBits = {chan1.lowPower, chan1.lgMix, chan1.lgConv, chan1.smConv, // R13
					chan2.lowPower, chan2.lgMix, chan2.lgConv, chan2.smConv};
			status_mux_pkg::ROW_GAIN2:
				rowBits = {chan2.gain[6:2], chan2.lgMix, chan2.lgConv, chan2.gainLock};
			status_mux_pkg::ROW_AGC2:
				rowBits = {chan2.gainChange, chan1.gainChange, chan2.lowPower,
					chan2.lgMix, chan2.lgConv, chan2.gainLock,
					chan2.energyLost, chan2.stronger};
			status_mux_pkg::ROW_GAIN1:
				rowBits = {chan1.lowPower, chan1.lgMix, chan1.lgConv, chan1.gain[6:2]};
			status_mux_pkg::ROW_AGC1:
				rowBits = {chan1.lowPower, chan1.lgMix, chan1.lgConv, chan1.smConv,
					chan1.agcState, chan1.gainLock};
			status_mux_pkg::ROW_FAST_AGC:
				rowBits = {chan1.stronger, chan1.gainLock, chan1.energyLost,
					chan1.gainChange, chan2.stronger, chan2.gainLock,
					chan2.energyLost, chan2.gainChange};
			status_mux_pkg::ROW_RXTX_ON:
				rowBits = {misc.rxOn, chan1.rssiPreRdy, chan1.rssiSymRdy, misc.txOn,
					chan2.rssiPreRdy, chan2.rssiSymRdy, 2'h0};
			status_mux_pkg::ROW_OVF1:
				rowBits = {chan1.overflow, 1'b0};
			status_mux_pkg::ROW_SEQ_STATE:
				rowBits = {misc.seqState, misc.radioState};
			status_mux_pkg::ROW_PEAK:
				rowBits = {chan1.energyLost, chan1.resetPeak, chan2.energyLost,
					chan2.resetPeak, misc.gainFreeze, chan1.digSat,
					chan2.digSat, 1'b0};
			status_mux_pkg::ROW_TX_QUAD:
				rowBits = {chan1.txQuadStatus, chan1.txQuadDone, calBusy.rfOffset,
					chan2.txQuadStatus, chan2.txQuadDone, 1'b0}; // R21
			status_mux_pkg::ROW_BB_DC:
				rowBits = {3'h0, calBusy.bbOffset, 4'h0};
			status_mux_pkg::ROW_STATE1:
				rowBits = {chan1.agcState, chan1.resetPeak, chan2.resetPeak,
					chan1.rfOffsetState, 1'b0};
			status_mux_pkg::ROW_STATE2:
				rowBits = {chan2.agcState, chan2.rssiEn, chan1.rssiEn,
					chan2.rfOffsetState, 1'b0}; // R23
			status_mux_pkg::ROW_AUX_WORD:
				rowBits = misc.auxWord[11:4];
			status_mux_pkg::ROW_POWER1:
				rowBits = {chan1.filtPwrRdy, chan1.gainLock, chan1.energyLost,
					chan1.stronger, chan1.convPwrRdy, chan1.agcState}; // R19
			status_mux_pkg::ROW_POWER2:
				rowBits = {chan2.filtPwrRdy, chan2.gainLock, chan2.energyLost,
					chan2.stronger, chan2.convPwrRdy, chan2.agcState}; // R19
			status_mux_pkg::ROW_OVF2:
				rowBits = {chan2.overflow, 1'b0}; // R22
			status_mux_pkg::ROW_TRACK1:
				rowBits = {chan1.signalPresent, chan1.dcUpdate, chan1.dcMeasure,
					chan1.dcTrackCnt, 4'h0}; // R16
			status_mux_pkg::ROW_INDEX1:
				rowBits = {chan1.gainLock, chan1.gain};
			status_mux_pkg::ROW_INDEX2:
				rowBits = {chan2.gainLock, chan2.gain};
			status_mux_pkg::ROW_TRACK2:
				rowBits = {chan2.signalPresent, chan2.dcUpdate, chan2.dcMeasure,
					chan2.dcTrackCnt, chan2.decPwrEn, chan2.convPwrEn,
					chan1.decPwrEn, chan1.convPwrEn}; // R17
			status_mux_pkg::ROW_PUMP_CODE:
				rowBits = {rxSynth.pumpCode, txSynth.pumpCode};
			status_mux_pkg::ROW_RX_LEVEL:
				rowBits = {rxSynth.tune[8], rxSynth.levelCode}; // R20
			status_mux_pkg::ROW_TX_LEVEL:
				rowBits = {txSynth.tune[8], txSynth.levelCode}; // R20
			status_mux_pkg::ROW_RX_TUNE:
				rowBits = rxSynth.tune[7:0]; // R20
			status_mux_pkg::ROW_TX_TUNE:
				rowBits = txSynth.tune[7:0]; // R20
			status_mux_pkg::ROW_THRESH1:
				rowBits = {chan1.lowThresh, chan1.highThresh, chan1.gainUpdExp,
					chan1.agcState[1:0], chan1.gainChange,
					misc.tempValid, misc.auxValid}; // R18
			status_mux_pkg::ROW_THRESH2:
				rowBits = {chan2.lowThresh, chan2.highThresh, chan2.gainUpdExp,
					chan2.agcState[1:0], chan2.gainChange, 2'h0};
			default:
				rowBits = 8'h00; // R14
		endcase
	end

	// pins registered so the host sees glitch-free levels, one cycle late
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			statusPins <= 8'h00;
		else if (cen)
			statusPins <= rowBits & enable_r; // R01

	// a listed run ending with nothing pending
	sequence s_run_end;
		cen && runPrev_r && !runActive;
	endsequence

	// a tx pump run ending
	sequence s_tx_pump_end;
		cen && pumpPrev_r[0] && !pumpBusy[0];
	endsequence

	a_enable_mask: assert property (@(posedge clk) disable iff (!resetn) // R01
		cen |=> ((statusPins & ~$past(enable_r)) == 8'h00))
		else $error("disabled status pin driven high");

	a_caldone_clear: assert property (@(posedge clk) disable iff (!resetn) // R02
		cen && listedBusy |=> !calDone_r)
		else $error("cal done high during calibration");

	a_caldone_rise: assert property (@(posedge clk) disable iff (!resetn) // R03
		s_run_end |=> calDone_r)
		else $error("cal done did not rise after runs");

	a_tx_pump: assert property (@(posedge clk) disable iff (!resetn) // R04
		s_tx_pump_end |=> pumpDone_r[0] ##0 (cen && !pumpBusy[0]) [*1] |=> pumpDone_r[0])
		else $error("tx pump done lost after run");

	a_rx_pump: assert property (@(posedge clk) disable iff (!resetn) // R05
		cen && pumpBusy[1] |=> !pumpDone_r[1])
		else $error("rx pump done high during run");

	a_filter_done: assert property (@(posedge clk) disable iff (!resetn) // R06
		cen && pointer_r == status_mux_pkg::ROW_CAL_DONE && enable_r[4]
		|=> statusPins[4] == !$past(calBusy.rxFilter))
		else $error("rx filter done pin wrong");

	a_vco_busy: assert property (@(posedge clk) disable iff (!resetn) // R24
		cen && pointer_r == status_mux_pkg::ROW_CAL_DONE && enable_r[0]
		|=> statusPins[0] == $past(calBusy.txVco))
		else $error("tx vco busy pin wrong");

	a_lock_zeros: assert property (@(posedge clk) disable iff (!resetn) // R09
		cen && pointer_r == status_mux_pkg::ROW_PLL_LOCK |=> statusPins[4:0] == 5'h00)
		else $error("lock row low pins not zero");

	a_lock_cal: assert property (@(posedge clk) disable iff (!resetn) // R10
		cen && pointer_r == status_mux_pkg::ROW_PLL_LOCK && !lockMode_r[0] && anyCalBusy
		|=> !statusPins[7])
		else $error("continuous lock high during cal");

	a_read_pointer: assert property (@(posedge clk) disable iff (!resetn) // R01
		cen && regReq.rd && regReq.addr == status_mux_pkg::ADDR_POINTER
		|=> rdData == $past(pointer_r))
		else $error("pointer read back wrong");
endmodule // status_output_mux

// ---- tb/host_monitor.sv ----
// host side model that waits on the status pins for calibration end
module host_monitor (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       startCal,
	input  wire logic [7:0] statusPins,
	output logic            hostBusy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic seenLow_r; // done pin dropped since start
	// busy from start until done rises again; a high seen too early is stale
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hostBusy  <= 1'b0;
			seenLow_r <= 1'b0;
		end
		else if (startCal)
		begin
			hostBusy  <= 1'b1;
			seenLow_r <= 1'b0;
		end
		else if (hostBusy && !statusPins[7])
			seenLow_r <= 1'b1;
		else if (hostBusy && seenLow_r)
			hostBusy <= 1'b0;
	end
endmodule // host_monitor

// ---- tb/tb_top.sv ----
// self-checking bench of the status output multiplexer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CW = $bits(status_mux_pkg::chan_stat_s);
	localparam int SW = $bits(status_mux_pkg::synth_cal_s);
	localparam int MW = $bits(status_mux_pkg::misc_stat_s);
	localparam logic [7:0] ROWS [15] = '{8'h02, 8'h03, 8'h0d, 8'h0e, 8'h10, 8'h12, 8'h13, 8'h14,
		8'h15, 8'h18, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e};
	logic                       clk;
	logic                       resetn;
	status_mux_pkg::reg_req_s   regReq;
	logic [7:0]                 rdData;
	logic [7:0]                 statusPins;
	status_mux_pkg::cal_busy_s  calBusy;
	status_mux_pkg::chan_stat_s chan1;
	status_mux_pkg::chan_stat_s chan2;
	status_mux_pkg::synth_cal_s txSynth;
	status_mux_pkg::synth_cal_s rxSynth;
	status_mux_pkg::misc_stat_s misc;
	logic [2:0]                 pllLockRaw;
	logic                       startCal;
	logic                       hostBusy;
	logic                       cen;          // clock enable, low freezes the block
	logic [1:0]                 intWordWrite; // integer word written per rf synth
	logic                       rdDly = 1'b0; // read issued last cycle
	logic                       pinChk;       // compare pins next edge
	logic [7:0]                 rdQ [$];      // expected read data
	logic [7:0]                 pinQ [$];     // expected pin values
	int                         failCount;
	int                         checks;

	status_output_mux i_status_output_mux (.clk(clk), .resetn(resetn), .cen(cen), .regReq(regReq),
		.rdData(rdData), .calBusy(calBusy), .chan1(chan1), .chan2(chan2), .txSynth(txSynth),
		.rxSynth(rxSynth), .misc(misc), .pllLockRaw(pllLockRaw), .intWordWrite(intWordWrite),
		.statusPins(statusPins));
	host_monitor i_host_monitor (.clk(clk), .resetn(resetn), .startCal(startCal),
		.statusPins(statusPins), .hostBusy(hostBusy));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		checks++;
		if (seen !== expd)
		begin
			failCount++;
			$display("FAIL %0t seen %h expected %h", $time, seen, expd);
		end
	endtask

	// monitor: pops the oldest note whenever a result is due
	always @(posedge clk)
	begin
		rdDly <= regReq.rd;
		if (rdDly)
			check(rdData, rdQ.pop_front());
		if (pinChk)
			check(statusPins, pinQ.pop_front());
	end

	// bus tasks leave one idle cycle so no strobe is set twice in a step
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		regReq <= '0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		regReq <= '0;
		@(posedge clk);
	endtask

	task automatic pins(input logic [7:0] e);
		pinQ.push_back(e);
		pinChk <= 1'b1;
		@(posedge clk);
		pinChk <= 1'b0;
		@(posedge clk);
	endtask

	// one calibration on the selected row: pins while running, then after
	task automatic calRun(input status_mux_pkg::cal_busy_s cb, input logic [7:0] dur, input logic [7:0] aft);
		calBusy <= cb;
		repeat (4) @(posedge clk);
		pins(dur);
		calBusy <= '0;
		repeat (4) @(posedge clk);
		pins(aft);
	endtask

	// expected row contents from what the bench drives
	function automatic logic [7:0] rowExp(input logic [7:0] r);
		case (r)
			8'h02: return {calBusy.bbOffset, calBusy.rfOffset, calBusy.rx1Quad, calBusy.tx1Quad,
				calBusy.rx2Quad, calBusy.tx2Quad, calBusy.gainStep, calBusy.txMon};
			8'h03: return {chan1.lowPower, chan1.lgMix, chan1.lgConv, chan1.smConv, chan2.lowPower,
				chan2.lgMix, chan2.lgConv, chan2.smConv};
			8'h0d: return {chan1.txQuadStatus, chan1.txQuadDone, calBusy.rfOffset, chan2.txQuadStatus,
				chan2.txQuadDone, 1'b0};
			8'h0e: return {3'h0, calBusy.bbOffset, 4'h0};
			8'h10: return {chan2.agcState, chan2.rssiEn, chan1.rssiEn, chan2.rfOffsetState, 1'b0};
			8'h12: return {chan1.filtPwrRdy, chan1.gainLock, chan1.energyLost, chan1.stronger,
				chan1.convPwrRdy, chan1.agcState};
			8'h13: return {chan2.filtPwrRdy, chan2.gainLock, chan2.energyLost, chan2.stronger,
				chan2.convPwrRdy, chan2.agcState};
			8'h14: return {chan2.overflow, 1'b0};
			8'h15: return {chan1.signalPresent, chan1.dcUpdate, chan1.dcMeasure, chan1.dcTrackCnt, 4'h0};
			8'h18: return {chan2.signalPresent, chan2.dcUpdate, chan2.dcMeasure, chan2.dcTrackCnt,
				chan2.decPwrEn, chan2.convPwrEn, chan1.decPwrEn, chan1.convPwrEn};
			8'h1a: return {rxSynth.tune[8], rxSynth.levelCode};
			8'h1b: return {txSynth.tune[8], txSynth.levelCode};
			8'h1c: return rxSynth.tune[7:0];
			8'h1d: return txSynth.tune[7:0];
			default: return {chan1.lowThresh, chan1.highThresh, chan1.gainUpdExp, chan1.agcState[1:0],
				chan1.gainChange, misc.tempValid, misc.auxValid};
		endcase
	endfunction

	// main sequence
	initial
	begin
		status_mux_pkg::cal_busy_s cb;
		logic [7:0]                mask;
		resetn = 1'b0;
		regReq = '0;
		calBusy = '0;
		chan1 = '0;
		chan2 = '0;
		txSynth = '0;
		rxSynth = '0;
		misc = '0;
		pllLockRaw = 3'h0;
		startCal = 1'b0;
		cen = 1'b1;
		intWordWrite = 2'h0;
		pinChk = 1'b0;
		failCount = 0;
		checks = 0;
		void'($urandom(48321));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		pins(8'h18);
		rd(status_mux_pkg::ADDR_ENABLE, 8'hff);
		rd(status_mux_pkg::ADDR_POINTER, 8'h00);
		rd(10'h3ff, 8'h00);
		// single calibrations seen on row zero
		cb = '0; cb.txVco = 1'b1; calRun(cb, 8'h19, 8'h18);
		cb = '0; cb.rxVco = 1'b1; calRun(cb, 8'h1a, 8'h18);
		cb = '0; cb.rxFilter = 1'b1; calRun(cb, 8'h08, 8'h18);
		cb = '0; cb.txFilter = 1'b1; calRun(cb, 8'h10, 8'h18);
		cb = '0; cb.gainStep = 1'b1; calRun(cb, 8'h1c, 8'h98);
		cb = '0; cb.txPump = 1'b1; calRun(cb, 8'h98, 8'hd8);
		cb = '0; cb.rxPump = 1'b1; calRun(cb, 8'hd8, 8'hf8);
		cb = '0; cb.txPump = 1'b1; calRun(cb, 8'hb8, 8'hf8);
		cb = '0; cb.bbOffset = 1'b1; calRun(cb, 8'h78, 8'hf8);
		// sequenced run: done stays low until the queue empties
		cb = '0; cb.rfOffset = 1'b1; cb.seqPending = 1'b1;
		calBusy <= cb;
		startCal <= 1'b1;
		@(posedge clk);
		startCal <= 1'b0;
		repeat (3) @(posedge clk);
		pins(8'h78);
		cb = '0; cb.seqPending = 1'b1;
		calBusy <= cb;
		repeat (4) @(posedge clk);
		pins(8'h78);
		calBusy <= '0;
		repeat (60) if (hostBusy !== 1'b0) @(posedge clk);
		pins(8'hf8);
		check({7'h00, hostBusy}, 8'h00);
		rd(status_mux_pkg::ADDR_STATUS, 8'h07);
		// lock row
		wr(status_mux_pkg::ADDR_POINTER, 8'h01);
		pllLockRaw <= 3'b100;
		repeat (8) @(posedge clk);
		pins(8'h20);
		pllLockRaw <= 3'b111;
		repeat (8) @(posedge clk);
		pins(8'he0);
		cb = '0; cb.gainStep = 1'b1; calRun(cb, 8'h20, 8'he0);
		// single shot on tx: result held once sampled, even after lock is lost
		wr(status_mux_pkg::ADDR_LOCKMODE, 8'h01);
		rd(status_mux_pkg::ADDR_LOCKMODE, 8'h01);
		pins(8'h60);
		intWordWrite <= 2'b01;
		@(posedge clk);
		intWordWrite <= 2'b00;
		cb = '0; cb.txVco = 1'b1; calRun(cb, 8'h20, 8'he0);
		pllLockRaw <= 3'b110;
		repeat (8) @(posedge clk);
		pins(8'he0);
		// clock enable low: a running rx vco cal must not reach the pins
		cb = '0; cb.rxVco = 1'b1;
		calBusy <= cb;
		cen <= 1'b0;
		repeat (4) @(posedge clk);
		pins(8'he0);
		cen <= 1'b1;
		calBusy <= '0;
		// random inputs and masks over the described rows
		repeat (2)
		begin
			foreach (ROWS[k])
			begin
				mask = 8'($urandom());
				chan1 <= CW'({$urandom(), $urandom()});
				chan2 <= CW'({$urandom(), $urandom()});
				txSynth <= SW'($urandom());
				rxSynth <= SW'($urandom());
				misc <= MW'($urandom());
				calBusy <= 15'($urandom());
				wr(status_mux_pkg::ADDR_ENABLE, mask);
				wr(status_mux_pkg::ADDR_POINTER, ROWS[k]);
				pins(rowExp(ROWS[k]) & mask);
				rd(status_mux_pkg::ADDR_POINTER, ROWS[k]);
			end
		end
		// let the monitor take the last read before the verdict
		@(posedge clk);
		conclude();
	end

	// watchdog far beyond the expected run length
	initial
	begin
		#200us;
		failCount++;
		conclude();
	end
endmodule // tb_top
